// File: rtl/ioxp_bus_if.sv
// open-drain i2c wires between the master end and the expander end
// assumes pull-ups: a line is low only while some party enables its driver
`timescale 1ns/10ps
interface ioxp_bus_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic scl_oe_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // wired-and of the open-drain drivers
  assign scl = ~(scl_oe_m | scl_oe_s);
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport mst (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport slv (output scl_oe_s, output sda_oe_s, input scl, input sda);
endinterface

// File: rtl/ioxp_master.sv
// master end: runs one byte transfer per request on sys_clk_i
// assumes the slave acknowledges; scl is divided down from sys_clk_i
`timescale 1ns/10ps
`include "ioxp_params.svh"
module ioxp_master #(
  parameter int DIV = `IOXP_SCL_DIV
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // bus
  ioxp_bus_if.mst bus,
  // request: send byte, optional start, stop, read, ack
  input wire logic req_i,
  input wire logic req_start_i,
  input wire logic req_stop_i,
  input wire logic req_read_i,
  input wire logic req_nack_i,
  input wire logic [7:0] req_data_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic ack_o,
  output logic [7:0] rd_data_o
);
  ioxp_pkg::ioxp_mst_state_t st_r;
  logic [$clog2(DIV)-1:0] div_r;
  logic [1:0] q_r; // quarter of the scl period
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic stop_r, read_r, nack_r, sda_q_r;
  logic [1:0] sda_sy_r;
  logic tick;
  assign tick = (div_r == '0);

  // quarter-period divider; a request restarts it so the first quarter is whole,
  // since the slave only reacts to an scl fall after its synchronisers and filter
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) div_r <= '0;
    else if (tick || (req_i && st_r == ioxp_pkg::IOXP_M_IDLE)) div_r <= $bits(div_r)'(DIV/4 - 1);
    else div_r <= div_r - 1'b1;
  end

  // sda comes back from the link clock domain: two flops before any use
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) sda_sy_r <= 2'h3;
    else sda_sy_r <= {sda_sy_r[0], bus.sda};
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ioxp_pkg::IOXP_M_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h0;
      stop_r <= 1'b0;
      read_r <= 1'b0;
      nack_r <= 1'b0;
      sda_q_r <= 1'b1;
      bus.scl_oe_m <= 1'b0;
      bus.sda_oe_m <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ack_o <= 1'b0;
      rd_data_o <= 8'h0;
    end else begin
      done_o <= 1'b0;
      unique case (st_r)
        ioxp_pkg::IOXP_M_IDLE: if (req_i) begin
          busy_o <= 1'b1;
          sh_r <= req_data_i;
          stop_r <= req_stop_i;
          read_r <= req_read_i;
          nack_r <= req_nack_i;
          bit_r <= 4'h0;
          q_r <= 2'h0;
          // a start is only issued from released lines
          st_r <= req_start_i ? ioxp_pkg::IOXP_M_START : ioxp_pkg::IOXP_M_BIT; // RULE_07
        end
        ioxp_pkg::IOXP_M_START: if (tick) begin
          q_r <= q_r + 2'h1;
          unique case (q_r)
            2'h0: bus.sda_oe_m <= 1'b0;
            2'h1: bus.scl_oe_m <= 1'b0;
            2'h2: bus.sda_oe_m <= 1'b1; // RULE_10
            2'h3: begin
              bus.scl_oe_m <= 1'b1;
              st_r <= ioxp_pkg::IOXP_M_BIT;
            end
          endcase
        end
        ioxp_pkg::IOXP_M_BIT: if (tick) begin
          q_r <= q_r + 2'h1;
          unique case (q_r)
            // data moves only while scl is low
            2'h0: begin
              if (bit_r == 4'h8) bus.sda_oe_m <= read_r & ~nack_r; // RULE_16 RULE_18
              else bus.sda_oe_m <= read_r ? 1'b0 : ~sh_r[7]; // RULE_08 RULE_14
            end
            2'h1: bus.scl_oe_m <= 1'b0;
            2'h2: sda_q_r <= sda_sy_r[1];
            2'h3: begin
              bus.scl_oe_m <= 1'b1;
              if (bit_r == 4'h8) begin // RULE_13
                ack_o <= ~sda_q_r;
                rd_data_o <= sh_r;
                st_r <= stop_r ? ioxp_pkg::IOXP_M_STOP : ioxp_pkg::IOXP_M_DONE;
              end else begin
                sh_r <= {sh_r[6:0], sda_q_r};
                bit_r <= bit_r + 4'h1;
              end
            end
          endcase
        end
        ioxp_pkg::IOXP_M_STOP: if (tick) begin
          q_r <= q_r + 2'h1;
          unique case (q_r)
            2'h0: bus.sda_oe_m <= 1'b1;
            2'h1: bus.scl_oe_m <= 1'b0;
            2'h2: bus.sda_oe_m <= 1'b0; // RULE_11 RULE_09
            2'h3: st_r <= ioxp_pkg::IOXP_M_DONE;
          endcase
        end
        ioxp_pkg::IOXP_M_DONE: begin
          done_o <= 1'b1;
          busy_o <= 1'b0;
          st_r <= ioxp_pkg::IOXP_M_IDLE;
        end
      endcase
    end
  end
endmodule // ioxp_master

// File: rtl/ioxp_params.svh
// constants for the i2c port expander link: address, register pairs, resets, timing
// assumes inclusion by both ends and the bench; definitions only
// Function
// RULE_01 - input pin change asserts interrupt
// RULE_02 - pin returning to old level releases interrupt
// RULE_03 - input register read releases, re-references interrupt
// RULE_04 - output pins never cause interrupt
// RULE_05 - interrupt cause tracked per 8-bit port
// RULE_06 - output-to-input switch may raise false interrupt
// RULE_07 - master starts transfers only when idle
// RULE_08 - one bit per scl pulse, sda moves low
// RULE_09 - idle means both lines released high
// RULE_10 - start is sda fall while scl high
// RULE_11 - stop is sda rise while scl high
// RULE_12 - no byte count limit per transfer
// RULE_13 - eight bits then one acknowledge slot
// RULE_14 - sender releases sda during acknowledge slot
// RULE_15 - device acknowledges every received byte
// RULE_16 - master acknowledges read bytes except last
// RULE_17 - acknowledge held low over high clock phase
// RULE_18 - master ends read with no acknowledge
// RULE_19 - after nack device releases sda
// RULE_20 - multi-byte read alternates within register pair
// RULE_21 - multi-byte write alternates within register pair
// RULE_22 - input captured on acknowledge clock falling edge
// RULE_23 - lines synchronised, filtered; interrupt open-drain low
`ifndef IOXP_PARAMS_SVH
`define IOXP_PARAMS_SVH
`define IOXP_ADDR_BASE 4'h4
`define IOXP_REG_IN0 3'h0
`define IOXP_REG_OUT0 3'h2
`define IOXP_REG_POL0 3'h4
`define IOXP_REG_CFG0 3'h6
`define IOXP_OUT_RST 8'hff
`define IOXP_POL_RST 8'h00
`define IOXP_CFG_RST 8'hff
`define IOXP_FILT_LEN 3
`define IOXP_SCL_DIV 16
`endif

// File: rtl/ioxp_pkg.sv
// types shared by both ends of the expander link
// assumes ioxp_params.svh holds the numbers
package ioxp_pkg;
  typedef enum logic [4:0] {
    IOXP_M_IDLE = 5'h01,
    IOXP_M_START = 5'h02,
    IOXP_M_BIT = 5'h04,
    IOXP_M_STOP = 5'h08,
    IOXP_M_DONE = 5'h10
  } ioxp_mst_state_t;
  typedef enum logic [3:0] {
    IOXP_S_IDLE = 4'h1,
    IOXP_S_RX = 4'h2,
    IOXP_S_ACK = 4'h4,
    IOXP_S_TX = 4'h8
  } ioxp_slv_state_t;
endpackage

// File: rtl/ioxp_slave.sv
// expander end: i2c slave on the link clock, register pairs, change interrupt
// assumes the link clock is free-running more than 14x the scl rate with the default filter
`timescale 1ns/10ps
`include "ioxp_params.svh"
module ioxp_slave #(
  parameter int FILT = `IOXP_FILT_LEN
) (
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic reset_i,
  // bus
  ioxp_bus_if.slv bus,
  // address straps and port pins
  input wire logic [2:0] addr_sel_i,
  input wire logic [15:0] pin_in_i,
  output logic [15:0] pin_out_o,
  output logic [15:0] pin_oe_o,
  // interrupt, open-drain enable (pin low while high)
  output logic int_oe_o
);
  logic [1:0] scl_sy_r, sda_sy_r;
  logic [15:0] pin_s1_r, pin_s2_r;
  logic [FILT-1:0] scl_h_r, sda_h_r;
  logic scl_f_r, sda_f_r, scl_d_r, sda_d_r;
  ioxp_pkg::ioxp_slv_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [1:0] phase_r; // 0 address, 1 command, 2 data
  logic rd_r, hit_r;
  logic [2:0] ptr_r;
  logic [15:0] in_r, out_r, pol_r, cfg_r;
  logic [15:0] ref_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic rd_ack_fall;
  logic [2:0] ld_ptr_c;
  logic [15:0] in_now_c;
  logic [7:0] ld_byte_c;

  // two-stage synchronisers, then a majority-free unanimity filter
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      pin_s1_r <= 16'hffff;
      pin_s2_r <= 16'hffff;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      pin_s1_r <= pin_in_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // filter rejects glitches shorter than FILT link clocks
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_h_r <= '1;
      sda_h_r <= '1;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_h_r <= {scl_h_r[FILT-2:0], scl_sy_r[1]}; // RULE_23
      sda_h_r <= {sda_h_r[FILT-2:0], sda_sy_r[1]};
      if (&scl_h_r) scl_f_r <= 1'b1;
      else if (~|scl_h_r) scl_f_r <= 1'b0;
      if (&sda_h_r) sda_f_r <= 1'b1;
      else if (~|sda_h_r) sda_f_r <= 1'b0;
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  assign scl_rise = scl_f_r & ~scl_d_r;
  assign scl_fall = ~scl_f_r & scl_d_r;
  assign start_c = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r; // RULE_10
  assign stop_c = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r; // RULE_11

  // byte read of one register out of the pairs
  function automatic logic [7:0] rd_byte(input logic [2:0] p, input logic [15:0] i, o, n, c);
    logic [15:0] v;
    v = 16'h0;
    unique case (p[2:1])
      2'h0: v = i ^ n;
      2'h1: v = o;
      2'h2: v = n;
      2'h3: v = c;
    endcase
    return p[0] ? v[15:8] : v[7:0];
  endfunction

  // byte to load for the next read slot; in tx the pointer still holds the byte just sent, so its pair partner is taken
  assign ld_ptr_c = (st_r == ioxp_pkg::IOXP_S_TX) ? {ptr_r[2:1], ~ptr_r[0]} : ptr_r;
  // the input register is captured on the same edge as the load, so the byte sees the fresh pins
  assign in_now_c = rd_ack_fall ? pin_s2_r : in_r;
  assign ld_byte_c = rd_byte(ld_ptr_c, in_now_c, out_r, pol_r, cfg_r);

  // serial slave state machine; sda only changes after scl falls
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ioxp_pkg::IOXP_S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h0;
      phase_r <= 2'h0;
      rd_r <= 1'b0;
      hit_r <= 1'b0;
      ptr_r <= 3'h0;
      bus.sda_oe_s <= 1'b0;
      out_r <= {2{`IOXP_OUT_RST}};
      pol_r <= {2{`IOXP_POL_RST}};
      cfg_r <= {2{`IOXP_CFG_RST}};
    end else if (start_c) begin
      st_r <= ioxp_pkg::IOXP_S_RX;
      cnt_r <= 4'h0;
      phase_r <= 2'h0;
      bus.sda_oe_s <= 1'b0;
    end else if (stop_c) begin
      st_r <= ioxp_pkg::IOXP_S_IDLE; // RULE_09
      bus.sda_oe_s <= 1'b0;
    end else begin
      unique case (st_r)
        ioxp_pkg::IOXP_S_IDLE: bus.sda_oe_s <= 1'b0;
        ioxp_pkg::IOXP_S_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_f_r}; // RULE_08
            cnt_r <= cnt_r + 4'h1;
          end
          if (scl_fall && cnt_r == 4'h8) begin // RULE_13
            cnt_r <= 4'h0;
            st_r <= ioxp_pkg::IOXP_S_ACK;
            if (phase_r == 2'h0) begin
              hit_r <= (sh_r[7:1] == {`IOXP_ADDR_BASE, addr_sel_i});
              rd_r <= sh_r[0];
              bus.sda_oe_s <= (sh_r[7:1] == {`IOXP_ADDR_BASE, addr_sel_i});
            end else begin
              bus.sda_oe_s <= hit_r; // RULE_15
              if (phase_r == 2'h1) ptr_r <= sh_r[2:0];
              else begin
                unique case (ptr_r[2:1])
                  2'h1: if (ptr_r[0]) out_r[15:8] <= sh_r; else out_r[7:0] <= sh_r;
                  2'h2: if (ptr_r[0]) pol_r[15:8] <= sh_r; else pol_r[7:0] <= sh_r;
                  2'h3: if (ptr_r[0]) cfg_r[15:8] <= sh_r; else cfg_r[7:0] <= sh_r;
                  default: ;
                endcase
                ptr_r <= {ptr_r[2:1], ~ptr_r[0]}; // RULE_21
              end
            end
          end
        end
        ioxp_pkg::IOXP_S_ACK: begin
          // ack stays driven across the whole ninth high phase
          if (scl_fall) begin // RULE_17
            if (!hit_r) begin
              st_r <= ioxp_pkg::IOXP_S_IDLE;
              bus.sda_oe_s <= 1'b0;
            end else if (rd_r && phase_r != 2'h2) begin
              st_r <= ioxp_pkg::IOXP_S_TX;
              phase_r <= 2'h2;
              sh_r <= ld_byte_c;
              bus.sda_oe_s <= ~ld_byte_c[7];
              cnt_r <= 4'h1;
            end else begin
              st_r <= ioxp_pkg::IOXP_S_RX; // RULE_12
              phase_r <= (phase_r == 2'h0) ? 2'h1 : 2'h2;
              bus.sda_oe_s <= 1'b0;
            end
          end
        end
        ioxp_pkg::IOXP_S_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              bus.sda_oe_s <= 1'b0; // RULE_14
              cnt_r <= 4'h9;
            end else if (cnt_r == 4'h9) begin
              if (sh_r[0]) begin
                st_r <= ioxp_pkg::IOXP_S_IDLE; // RULE_19
                bus.sda_oe_s <= 1'b0;
              end else begin
                ptr_r <= ld_ptr_c; // RULE_20
                sh_r <= ld_byte_c;
                bus.sda_oe_s <= ~ld_byte_c[7];
                cnt_r <= 4'h1;
              end
            end else begin
              bus.sda_oe_s <= ~sh_r[6];
              sh_r <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end else if (scl_rise && cnt_r == 4'h9) begin
            sh_r[0] <= sda_f_r; // master acknowledge sampled here
          end
        end
        default: st_r <= ioxp_pkg::IOXP_S_IDLE;
      endcase
    end
  end

  // ack falls that load a read byte; a missing master ack ends the read and loads nothing
  assign rd_ack_fall = ((st_r == ioxp_pkg::IOXP_S_TX) && scl_fall && cnt_r == 4'h9 && !sh_r[0])
    || ((st_r == ioxp_pkg::IOXP_S_ACK) && scl_fall && hit_r && rd_r && phase_r != 2'h2);

  // input register snapshot and per-port change reference
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_r <= 16'h0;
      ref_r <= 16'h0;
    end else begin
      if (rd_ack_fall) begin
        in_r <= pin_s2_r; // RULE_22
      end
      // reading a port re-references only the port whose byte is being sent
      if (rd_ack_fall && ld_ptr_c[2:1] == 2'h0) begin // RULE_05
        if (ld_ptr_c[0]) ref_r[15:8] <= pin_s2_r[15:8]; // RULE_03
        else ref_r[7:0] <= pin_s2_r[7:0];
      end
    end
  end

  // interrupt is a live compare so a pin returning clears it; outputs masked
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) int_oe_o <= 1'b0;
    else int_oe_o <= |((pin_s2_r ^ ref_r) & cfg_r); // RULE_01 RULE_02 RULE_04 RULE_06
  end

  // pin drivers
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_out_o <= {2{`IOXP_OUT_RST}};
      pin_oe_o <= 16'h0;
    end else begin
      pin_out_o <= out_r;
      pin_oe_o <= ~cfg_r;
    end
  end
  assign bus.scl_oe_s = 1'b0;
endmodule // ioxp_slave

// File: test/ioxp_monitor.sv
// checker for the expander link: framing, acknowledge and release on the wires
// assumes sys_clk_i samples far faster than scl and every address is ours
`timescale 1ns/10ps
module ioxp_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // interface wires
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic scl_oe_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r;
  logic sda_r;
  logic first_r;
  logic [3:0] bit_cnt_r;
  logic start_w;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // start seen when sda falls while scl stays high
  assign start_w = scl && scl_r && sda_r && !sda;
  // previous line levels for edge detection
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // scl rises since start; 9 marks the acknowledge pulse
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_r <= 4'h0;
    end else if (start_w) begin
      bit_cnt_r <= 4'h0;
    end else if (scl && !scl_r) begin
      bit_cnt_r <= (bit_cnt_r == 4'h9) ? 4'h1 : bit_cnt_r + 4'h1;
    end
  end
  // address byte runs from start to the fall of its acknowledge pulse
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_r <= 1'b0;
    end else if (start_w) begin
      first_r <= 1'b1;
    end else if (!scl && scl_r && bit_cnt_r == 4'h9) begin
      first_r <= 1'b0;
    end
  end
  slave_scl_a: assert property (!scl_oe_s) else $error("slave drove scl");
  slave_edge_a: assert property ($changed(sda_oe_s) |-> !scl && !$past(scl))
    else $error("slave moved sda while scl high");
  start_cond_a: assert property (scl && $fell(sda) |-> sda_oe_m && !sda_oe_s)
    else $error("start not made by master alone");
  stop_idle_a: assert property (scl && $rose(sda) |-> (!sda_oe_s && !scl_oe_m) ##1 (scl && sda) [*8])
    else $error("bus not idle after stop");
  addr_bits_a: assert property (first_r && scl && scl_r && bit_cnt_r inside {[4'h1:4'h8]} |-> !sda_oe_s)
    else $error("slave drove sda in address bits");
  addr_ack_a: assert property (first_r && scl && bit_cnt_r == 4'h9 |-> sda_oe_s && !sda_oe_m)
    else $error("address acknowledge missing");
  nack_release_a: assert property ($fell(scl) && bit_cnt_r == 4'h9 && $past(sda) |->
    !sda_oe_s until (scl && $rose(sda))) else $error("slave drove sda after no acknowledge");
  nack_stop_a: assert property ($fell(scl) && bit_cnt_r == 4'h9 && $past(sda) |->
    ##[1:1000] (scl && $rose(sda))) else $error("no stop after no acknowledge");
endmodule // ioxp_monitor

// File: test/test_i2c_expander_bus_and_change_irq.sv
// self-checking bench: master end and expander end joined by the link interface
// assumes the design files and ioxp_params.svh are compiled first
`timescale 1ns/10ps
`include "ioxp_params.svh"
module test_i2c_expander_bus_and_change_irq;
  localparam int DIV = 512;
  localparam logic [7:0] dev_w = {`IOXP_ADDR_BASE, 3'h5, 1'b0};
  localparam logic [7:0] dev_r = {`IOXP_ADDR_BASE, 3'h5, 1'b1};
  localparam logic [7:0] cmd_cfg = {5'h00, `IOXP_REG_CFG0};
  localparam logic [7:0] cmd_in0 = {5'h00, `IOXP_REG_IN0};
  localparam logic [7:0] cmd_in1 = {5'h00, `IOXP_REG_IN0} + 8'h01;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_i = 1'b0;
  logic req_start_i = 1'b0;
  logic req_stop_i = 1'b0;
  logic req_read_i = 1'b0;
  logic req_nack_i = 1'b0;
  logic [7:0] req_data_i = 8'h00;
  logic busy_o;
  logic done_o;
  logic ack_o;
  logic [7:0] rd_data_o;
  logic [15:0] pin_in_i = 16'h0000;
  logic [15:0] pin_out_o;
  logic [15:0] pin_oe_o;
  logic int_oe_o;
  logic [8:0] wire_bits = 9'h000;
  int miscompares = 0;
  int checked = 0;
  // clocks; the link clock starts off-phase so edges never line up
  always #2 sys_clk_i = ~sys_clk_i;
  initial begin
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end
  ioxp_bus_if ioxp_bus_if_i ();
  ioxp_master #(.DIV(DIV)) ioxp_master_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus(ioxp_bus_if_i),
    .req_i(req_i), .req_start_i(req_start_i), .req_stop_i(req_stop_i), .req_read_i(req_read_i),
    .req_nack_i(req_nack_i), .req_data_i(req_data_i), .busy_o(busy_o), .done_o(done_o), .ack_o(ack_o),
    .rd_data_o(rd_data_o));
  // shorter filter keeps a quarter scl period above the filter length
  ioxp_slave #(.FILT(2)) ioxp_slave_i (.link_clk_i(link_clk_i), .reset_i(reset_i), .bus(ioxp_bus_if_i),
    .addr_sel_i(3'h5), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .int_oe_o(int_oe_o));
  ioxp_monitor ioxp_monitor_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_oe_m(ioxp_bus_if_i.scl_oe_m),
    .sda_oe_m(ioxp_bus_if_i.sda_oe_m), .scl_oe_s(ioxp_bus_if_i.scl_oe_s), .sda_oe_s(ioxp_bus_if_i.sda_oe_s),
    .scl(ioxp_bus_if_i.scl), .sda(ioxp_bus_if_i.sda));
  // sda at each scl rise; the last nine hold a byte and its acknowledge
  always @(posedge ioxp_bus_if_i.scl) wire_bits <= {wire_bits[7:0], ioxp_bus_if_i.sda};
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one byte through the master; e is the byte expected on the wire
  task automatic xfer(input logic st, sp, rd, nk, input logic [7:0] d, e);
    int n;
    n = 0;
    req_start_i = st;
    req_stop_i = sp;
    req_read_i = rd;
    req_nack_i = nk;
    req_data_i = d;
    req_i = 1'b1;
    @(posedge sys_clk_i);
    #1 req_i = 1'b0;
    check("busy_o", {15'h0000, busy_o}, 16'h0001);
    while (done_o !== 1'b1) begin
      @(posedge sys_clk_i);
      #1 n++;
      if (n > 20000) begin
        miscompares++;
        $display("mismatch done_o expected 1 seen 0");
        finish_test();
      end
    end
    check("busy_o", {15'h0000, busy_o}, 16'h0000);
    if (rd) check("rd_data_o", {8'h00, rd_data_o}, {8'h00, e});
    else check("ack_o", {15'h0000, ack_o}, 16'h0001);
    // a stop adds one rise with sda low after the acknowledge
    check("wire bits", {7'h00, wire_bits}, sp ? {7'h00, e[6:0], nk, 1'b0} : {7'h00, e, nk});
  endtask
  // let pin changes cross into the link domain, then wait for the level
  task automatic wait_int(input logic exp);
    int n;
    n = 0;
    repeat (8) @(posedge link_clk_i);
    while (int_oe_o !== exp) begin
      @(posedge link_clk_i);
      #1 n++;
      if (n > 40) begin
        miscompares++;
        $display("mismatch int_oe_o expected %b seen %b", exp, int_oe_o);
        finish_test();
      end
    end
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic write_cfg(input logic [7:0] first, input logic [7:0] second, input logic two);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_w, dev_w);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, cmd_cfg, cmd_cfg);
    xfer(1'b0, !two, 1'b0, 1'b0, first, first);
    if (two) xfer(1'b0, 1'b1, 1'b0, 1'b0, second, second);
  endtask
  task automatic read_reg(input logic [7:0] cmd, input int n, input logic [15:0] exp);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_w, dev_w);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, cmd, cmd);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_r, dev_r);
    for (int i = 0; i < n; i++) begin
      xfer(1'b0, (i == n - 1), 1'b1, (i == n - 1), 8'h00, i[0] ? exp[15:8] : exp[7:0]);
    end
    check("idle lines", {14'h0000, ioxp_bus_if_i.scl, ioxp_bus_if_i.sda}, 16'h0003);
  endtask
  task automatic t_idle();
    check("idle lines", {14'h0000, ioxp_bus_if_i.scl, ioxp_bus_if_i.sda}, 16'h0003);
    check("pin_oe_o", pin_oe_o, 16'h0000);
    check("pin_out_o", pin_out_o, {2{`IOXP_OUT_RST}});
    wait_int(1'b0);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0000);
    $display("test idle finished");
  endtask
  task automatic t_config();
    write_cfg(8'h0f, 8'hff, 1'b1);
    check("pin_oe_o", pin_oe_o, 16'h00f0);
    $display("test config finished");
  endtask
  task automatic t_change();
    pin_in_i[0] = 1'b1;
    wait_int(1'b1);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0001);
    pin_in_i[0] = 1'b0;
    wait_int(1'b0);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0000);
    pin_in_i[4] = 1'b1;
    wait_int(1'b0);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0000);
    // pin 4 turns input while differing from its stored level
    write_cfg(8'hff, 8'h00, 1'b0);
    wait_int(1'b1);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0001);
    $display("test change finished");
  endtask
  task automatic t_ports();
    pin_in_i[8] = 1'b1;
    read_reg(cmd_in0, 1, 16'h0010);
    wait_int(1'b1);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0001);
    read_reg(cmd_in1, 2, 16'h1001);
    wait_int(1'b0);
    check("int_oe_o", {15'h0000, int_oe_o}, 16'h0000);
    $display("test ports finished");
  endtask
  // reset spans 16 link clocks so both domains see it
  initial begin
    repeat (16) @(posedge link_clk_i);
    @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge link_clk_i);
    @(posedge sys_clk_i);
    #1;
    t_idle();
    t_config();
    t_change();
    t_ports();
    finish_test();
  end
endmodule // test_i2c_expander_bus_and_change_irq
